// [sed_pkg.sv]
/*
  Constants for the supply enable and voltage transition register block:
  register offsets, field positions, reset values and deglitch timing.
  Assumes the internal logic clock runs at 50 MHz.
*/
package sed_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_ENA        = 8'h10;
	localparam logic [7:0] ADDR_ENB        = 8'h11;
	localparam logic [7:0] ADDR_ENC        = 8'h12;
	localparam logic [7:0] ADDR_END        = 8'h13;
	localparam logic [7:0] ADDR_MODE       = 8'h14;
	localparam logic [7:0] ADDR_VCTL_ONE   = 8'h20;
	localparam logic [7:0] ADDR_VCTL_TWO   = 8'h21;
	localparam logic [7:0] ADDR_VSET_BASE  = 8'h30;
	localparam int         NUM_VSET        = 10;
	localparam int         NUM_DVM         = 5;
	localparam int         NUM_SUPPLY      = 13;

	// ==========================================================
	// Field positions and masks
	localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0F;
	localparam int         MODE_LR9        = 7;
	localparam int         MODE_LR5        = 6;
	localparam int         MODE_SYSIN      = 5;
	localparam int         MODE_HOT_RESET_DEGLITCH_SELECT     = 4;
	localparam int         MODE_SLEEP      = 3;
	localparam int         MODE_NORMAL     = 2;
	localparam int         MODE_EXIT       = 1;
	localparam int         MODE_SOFTRST    = 0;
	localparam logic [7:0] MODE_STORE_MASK = 8'hF2;
	localparam logic [7:0] VCTL_ONE_GO     = 8'h55;
	localparam logic [7:0] VCTL_TWO_GO     = 8'h55;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE        = 8'h00;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS      = 20;
	localparam int DEGLITCH_SHORT_NS  = 5000;
	localparam int DEGLITCH_SHORT_CYC = (DEGLITCH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEGLITCH_LONG_MS   = 5;
	localparam int DEGLITCH_LONG_CYC  = (DEGLITCH_LONG_MS * 1000000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		DG_IDLE  = 2'b00,
		DG_COUNT = 2'b01,
		DG_FIRED = 2'b10
	} sed_dg_state_t;

endpackage

// [sed_supply_enable_dvm.sv]
/*
  Supply enable, system mode and voltage transition register logic.
  Assumes the serial register engine presents single-cycle read and write
  strobes on the logic clock, and that the slew logic and factory
  configuration are on the same clock.
*/
`timescale 1ns/1ps

module sed_supply_enable_dvm #(
	parameter int DEGLITCH_LONG_CYCLES = sed_pkg::DEGLITCH_LONG_CYC
) (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	// Register port from the serial engine
	input  wire logic        wr_en_in,
	input  wire logic        rd_en_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [7:0]  wr_data_in,
	output logic      [7:0]  rd_data_out,
	// Factory enable defaults, one byte per enable register
	input  wire logic [39:0] factory_enable_in,
	// Pins
	input  wire logic        buck_a_pin_on_in,
	input  wire logic        buck_b_pin_on_in,
	input  wire logic        linreg_four_pin_on_in,
	input  wire logic        sys_input_low_in,
	input  wire logic        hot_reset_in,
	// Slew logic
	input  wire logic [4:0]  ramp_done_in,
	output logic [4:0]       ramp_start_out,
	output logic [4:0]       ramp_active_out,
	output logic [39:0]      target_code_out,
	// Supplies and sequencer
	output logic [12:0]      supply_on_out,
	output logic             sleep_req_out,
	output logic             normal_req_out,
	output logic             reboot_req_out,
	output logic             sleep_request_exit_out,
	output logic             hot_reset_out
);

	// ==========================================================
	// Registers
	logic [7:0] ena_q, enb_q, enc_q, end_q, mode_q, vctl1_q, vctl2_q;
	logic [7:0] ena_d, enb_d, enc_d, end_d, mode_d, vctl1_d, vctl2_d;
	logic [7:0] vset_q [sed_pkg::NUM_VSET];
	logic       load_q;
	logic [1:0] pin_a_s, pin_b_s, pin_4_s, low_s, hot_s;
	logic       low_prev_q;

	// ==========================================================
	// Address decode
	wire wr_ena   = wr_en_in && (addr_in == sed_pkg::ADDR_ENA);
	wire wr_enb   = wr_en_in && (addr_in == sed_pkg::ADDR_ENB);
	wire wr_enc   = wr_en_in && (addr_in == sed_pkg::ADDR_ENC);
	wire wr_end   = wr_en_in && (addr_in == sed_pkg::ADDR_END);
	wire wr_mode  = wr_en_in && (addr_in == sed_pkg::ADDR_MODE);
	wire wr_vctl1 = wr_en_in && (addr_in == sed_pkg::ADDR_VCTL_ONE);
	wire wr_vctl2 = wr_en_in && (addr_in == sed_pkg::ADDR_VCTL_TWO);
	wire [7:0] vset_idx = addr_in - sed_pkg::ADDR_VSET_BASE;
	wire in_vset = (addr_in >= sed_pkg::ADDR_VSET_BASE) &&
		(vset_idx < 8'(sed_pkg::NUM_VSET));

	// ==========================================================
	// Enable registers
	assign ena_d = wr_ena ? (wr_data_in & sed_pkg::LOW_NIBBLE_MASK) : ena_q;
	assign enb_d = wr_enb ? (wr_data_in & sed_pkg::LOW_NIBBLE_MASK) : enb_q;
	assign enc_d = wr_enc ? wr_data_in : enc_q;
	assign end_d = wr_end ? wr_data_in : end_q;
	// The sleep, normal and soft reset action bits are pulses and never stored, so they read as zero.
	assign mode_d = wr_mode ? (wr_data_in & sed_pkg::MODE_STORE_MASK) : mode_q;

	wire [39:0] fac = factory_enable_in;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			load_q <= 1'b1;
			ena_q  <= sed_pkg::RST_BYTE;
			enb_q  <= sed_pkg::RST_BYTE;
			enc_q  <= sed_pkg::RST_BYTE;
			end_q  <= sed_pkg::RST_BYTE;
			mode_q <= sed_pkg::RST_BYTE;
		end else if (load_q) begin
			// Defaults are caught one cycle after release, never under reset.
			load_q <= 1'b0;
			ena_q  <= fac[7:0] & sed_pkg::LOW_NIBBLE_MASK;
			enb_q  <= fac[15:8] & sed_pkg::LOW_NIBBLE_MASK;
			enc_q  <= fac[23:16];
			end_q  <= fac[31:24];
			mode_q <= {fac[39:38], 6'h00};
		end else begin
			ena_q  <= ena_d;
			enb_q  <= enb_d;
			enc_q  <= enc_d;
			end_q  <= end_d;
			mode_q <= mode_d;
		end
	end

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pin_a_s <= 2'h0;
			pin_b_s <= 2'h0;
			pin_4_s <= 2'h0;
			low_s   <= 2'h0;
			hot_s   <= 2'h0;
		end else begin
			pin_a_s <= {pin_a_s[0], buck_a_pin_on_in};
			pin_b_s <= {pin_b_s[0], buck_b_pin_on_in};
			pin_4_s <= {pin_4_s[0], linreg_four_pin_on_in};
			low_s   <= {low_s[0], sys_input_low_in};
			hot_s   <= {hot_s[0], hot_reset_in};
		end
	end

	// ==========================================================
	// Supply on/off: 0 buck_a, 1 buck_b, 2 buck_c, 3..12 linreg 0..9
	logic [12:0] on_d;
	assign on_d[0]  = ena_d[1] | enb_d[1] | pin_a_s[1];
	assign on_d[1]  = ena_d[0] | enb_d[0] | pin_b_s[1];
	assign on_d[2]  = enc_d[7] | end_d[7];
	assign on_d[3]  = enc_d[0] | end_d[0];
	assign on_d[4]  = enc_d[1] | end_d[1];
	assign on_d[5]  = |{ena_d[3:2], enb_d[3:2]};
	assign on_d[6]  = enc_d[2] | end_d[2];
	assign on_d[7]  = enc_d[3] | end_d[3] | pin_4_s[1];
	assign on_d[8]  = mode_d[sed_pkg::MODE_LR5];
	assign on_d[9]  = enc_d[4] | end_d[4];
	assign on_d[10] = enc_d[5] | end_d[5];
	assign on_d[11] = enc_d[6] | end_d[6];
	assign on_d[12] = mode_d[sed_pkg::MODE_LR9];

	always_ff @(posedge clock_in) begin
		if (rst_in || load_q) begin
			supply_on_out <= 13'h0000;
		end else begin
			supply_on_out <= on_d;
		end
	end

	// ==========================================================
	// System mode requests
	wire low_rise = low_s[1] & ~low_prev_q;
	wire mode_one = wr_mode & wr_data_in[sed_pkg::MODE_SLEEP];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			low_prev_q             <= 1'b0;
			sleep_req_out          <= 1'b0;
			normal_req_out         <= 1'b0;
			reboot_req_out         <= 1'b0;
			sleep_request_exit_out <= 1'b0;
		end else begin
			low_prev_q     <= low_s[1];
			sleep_req_out  <= mode_one | (low_rise & mode_q[sed_pkg::MODE_SYSIN]);
			normal_req_out <= wr_mode & wr_data_in[sed_pkg::MODE_NORMAL];
			reboot_req_out <= wr_mode & wr_data_in[sed_pkg::MODE_SOFTRST];
			sleep_request_exit_out <= mode_d[sed_pkg::MODE_EXIT];
		end
	end

	// ==========================================================
	// Hot reset deglitch
	// The short setting waits the minimum time; the maximum is then met
	// with margin at this clock rate.
	sed_pkg::sed_dg_state_t dg_q, dg_d;
	logic [31:0] dg_cnt_q;
	wire  [31:0] dg_limit = mode_q[sed_pkg::MODE_HOT_RESET_DEGLITCH_SELECT] ?
		32'(DEGLITCH_LONG_CYCLES) : 32'(sed_pkg::DEGLITCH_SHORT_CYC);

	always_comb begin
		dg_d = dg_q;
		case (dg_q)
			sed_pkg::DG_IDLE: begin
				if (hot_s[1]) dg_d = sed_pkg::DG_COUNT;
			end
			sed_pkg::DG_COUNT: begin
				if (!hot_s[1]) dg_d = sed_pkg::DG_IDLE;
				else if (dg_cnt_q >= dg_limit - 32'h1) dg_d = sed_pkg::DG_FIRED;
			end
			sed_pkg::DG_FIRED: begin
				if (!hot_s[1]) dg_d = sed_pkg::DG_IDLE;
			end
			default: dg_d = sed_pkg::DG_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			dg_q          <= sed_pkg::DG_IDLE;
			dg_cnt_q      <= 32'h0;
			hot_reset_out <= 1'b0;
		end else begin
			dg_q          <= dg_d;
			dg_cnt_q      <= (dg_q == sed_pkg::DG_COUNT) ? dg_cnt_q + 32'h1 : 32'h0;
			hot_reset_out <= (dg_q == sed_pkg::DG_COUNT) && (dg_d == sed_pkg::DG_FIRED);
		end
	end

	// ==========================================================
	// Voltage control: 0 buck_a, 1 buck_b, 2 linreg two A, 3 linreg two B, 4 linreg four
	// Start bits are write-one-to-set; a write in the cycle of completion wins.
	wire [7:0] done1 = {1'b0, ramp_done_in[4], 1'b0, ramp_done_in[2],
		1'b0, ramp_done_in[0], 1'b0, ramp_done_in[1]};
	wire [7:0] done2 = {1'b0, ramp_done_in[3], 1'b0, ramp_done_in[2],
		1'b0, ramp_done_in[0], 1'b0, ramp_done_in[1]};
	wire [7:0] set1 = wr_vctl1 ? (wr_data_in & sed_pkg::VCTL_ONE_GO) : 8'h00;
	wire [7:0] set2 = wr_vctl2 ? (wr_data_in & sed_pkg::VCTL_TWO_GO) : 8'h00;
	wire [7:0] sel1 = wr_vctl1 ? (wr_data_in & ~sed_pkg::VCTL_ONE_GO) : (vctl1_q & ~sed_pkg::VCTL_ONE_GO);
	wire [7:0] sel2 = wr_vctl2 ? (wr_data_in & ~sed_pkg::VCTL_TWO_GO) : (vctl2_q & ~sed_pkg::VCTL_TWO_GO);
	assign vctl1_d = sel1 | set1 | (vctl1_q & sed_pkg::VCTL_ONE_GO & ~done1);
	assign vctl2_d = sel2 | set2 | (vctl2_q & sed_pkg::VCTL_TWO_GO & ~done2);

	wire [4:0] start = {set1[6], set2[6], set1[4] | set2[4], set1[0] | set2[0],
		set1[2] | set2[2]};
	wire [4:0] sel = {vctl1_d[7], vctl2_d[7], vctl2_d[5], vctl1_d[1] | vctl2_d[1],
		vctl1_d[3] | vctl2_d[3]};

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			vctl1_q         <= sed_pkg::RST_BYTE;
			vctl2_q         <= sed_pkg::RST_BYTE;
			ramp_start_out  <= 5'h00;
			ramp_active_out <= 5'h00;
		end else begin
			vctl1_q         <= vctl1_d;
			vctl2_q         <= vctl2_d;
			ramp_start_out  <= start;
			ramp_active_out <= {vctl1_d[6], vctl2_d[6], vctl1_d[4] | vctl2_d[4],
				vctl1_d[0] | vctl2_d[0], vctl1_d[2] | vctl2_d[2]};
		end
	end

	// Setting codes are plain storage; the slew logic sees a code only at start.
	genvar g;
	generate
		for (g = 0; g < sed_pkg::NUM_DVM; g++) begin : g_dvm
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					vset_q[2*g]     <= sed_pkg::RST_BYTE;
					vset_q[2*g+1]   <= sed_pkg::RST_BYTE;
					target_code_out[8*g +: 8] <= sed_pkg::RST_BYTE;
				end else begin
					if (wr_en_in && in_vset && vset_idx == 8'(2*g)) vset_q[2*g] <= wr_data_in;
					if (wr_en_in && in_vset && vset_idx == 8'(2*g+1)) vset_q[2*g+1] <= wr_data_in;
					if (start[g]) target_code_out[8*g +: 8] <= sel[g] ? vset_q[2*g+1] : vset_q[2*g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Read back
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (addr_in)
			sed_pkg::ADDR_ENA:      rd_mux = ena_q;
			sed_pkg::ADDR_ENB:      rd_mux = enb_q;
			sed_pkg::ADDR_ENC:      rd_mux = enc_q;
			sed_pkg::ADDR_END:      rd_mux = end_q;
			sed_pkg::ADDR_MODE:     rd_mux = mode_q;
			sed_pkg::ADDR_VCTL_ONE: rd_mux = vctl1_q;
			sed_pkg::ADDR_VCTL_TWO: rd_mux = vctl2_q;
			default:                rd_mux = in_vset ? vset_q[vset_idx[3:0]] : 8'h00;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= rd_mux;
		end
	end

endmodule // sed_supply_enable_dvm

// [sed_host_model.sv]
/*
  Host side model: single-cycle register write and read strobes.
  Assumes one bench process calls its task, driving at the falling edge.
*/
`timescale 1ns/1ps

module sed_host_model (
	// Clock
	input  wire logic       clock_in,
	// Register strobes
	output logic            wr_en_out,
	output logic            rd_en_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] data_out
);
	// ==========================================================
	// Bus cycle
	// Released address and data lines carry the inverse value and the strobes drop to zero, so a late sample cannot pass.
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out  = 8'h00;
		data_out  = 8'h00;
	end

	task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_in);
		wr_en_out = w;
		rd_en_out = ~w;
		addr_out  = a;
		data_out  = d;
		@(negedge clock_in);
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out  = ~a;
		data_out  = ~d;
	endtask
endmodule // sed_host_model

// [sed_chk_sva.sv]
/*
  Checker for the supply enable block: write effects, pulses, ramp control.
  Assumes synchronous active-high reset and no write in the load cycle.
*/
`timescale 1ns/1ps

module sed_chk (
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire logic        wr_en_in,
	input wire logic        rd_en_in,
	input wire logic [7:0]  addr_in,
	input wire logic [7:0]  wr_data_in,
	input wire logic [7:0]  rd_data_out,
	input wire logic [4:0]  ramp_done_in,
	input wire logic [4:0]  ramp_start_out,
	input wire logic [4:0]  ramp_active_out,
	input wire logic [12:0] supply_on_out,
	input wire logic        sleep_req_out,
	input wire logic        normal_req_out,
	input wire logic        reboot_req_out,
	input wire logic        sleep_request_exit_out,
	input wire logic        hot_reset_out
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	wire logic mode_wr = wr_en_in && addr_in == sed_pkg::ADDR_MODE;
	wire logic go_wr   = wr_en_in && wr_data_in[2] &&
		(addr_in == sed_pkg::ADDR_VCTL_ONE || addr_in == sed_pkg::ADDR_VCTL_TWO);

	property p_sleep; mode_wr && wr_data_in[3] |=> sleep_req_out; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep pulse missing");
	property p_normal; mode_wr && wr_data_in[2] |=> normal_req_out; endproperty
	a_normal: assert property (p_normal) else $error("normal pulse missing");
	property p_reboot; mode_wr && wr_data_in[0] |=> reboot_req_out; endproperty
	a_reboot: assert property (p_reboot) else $error("reboot pulse missing");
	property p_cause; $rose(reboot_req_out) |-> $past(mode_wr && wr_data_in[0]); endproperty
	a_cause: assert property (p_cause) else $error("reboot without write");
	property p_single;
		mode_wr |=> supply_on_out[12] == $past(wr_data_in[7]) &&
			supply_on_out[8] == $past(wr_data_in[6]);
	endproperty
	a_single: assert property (p_single) else $error("single bit supply wrong");
	property p_exit; mode_wr |=> sleep_request_exit_out == $past(wr_data_in[1]); endproperty
	a_exit: assert property (p_exit) else $error("exit level wrong");
	property p_or; wr_en_in && addr_in == sed_pkg::ADDR_ENA && wr_data_in[1] |=> supply_on_out[0];
	endproperty
	a_or: assert property (p_or) else $error("enable bit ignored");
	property p_go; go_wr |=> ramp_start_out[0] && ramp_active_out[0]; endproperty
	a_go: assert property (p_go) else $error("ramp not started");
	property p_done; ramp_done_in[0] && !go_wr |=> !ramp_active_out[0]; endproperty
	a_done: assert property (p_done) else $error("start bit not cleared");
	property p_rsvd;
		rd_en_in && (addr_in == sed_pkg::ADDR_ENA || addr_in == sed_pkg::ADDR_ENB)
			|=> rd_data_out[7:4] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("unused bits read high");

	c_ramp: cover property (ramp_done_in[0] && ramp_active_out[0]);
	c_sleep: cover property (sleep_req_out);
	c_hot: cover property (hot_reset_out);
endmodule // sed_chk

bind sed_supply_enable_dvm sed_chk u_chk (.*);

// [testbench.sv]
/*
  Self-checking bench for the supply enable and voltage transition block.
  Assumes the checker is bound from its own file and a shortened long deglitch.
*/
`timescale 1ns/1ps

module testbench;
	// ==========================================================
	// Signals
	logic        clock_in, rst_in, wr_en, rd_en, bpa, bpb, lfp, sil, hri, rd_pend = 1'b0;
	logic        sreq, nreq, rreq, sexit, hrst;
	logic [7:0]  addr, wdata, rdata;
	logic [39:0] fac, tgt;
	logic [4:0]  done, rstart, ract;
	logic [12:0] son;
	logic [7:0]  r [5];
	logic [7:0]  exp_q [$];
	logic [31:0] seed = 32'h0000_0CDA;
	int          n_errors = 0, check_count = 0, hr_cnt = 0, sl_cnt = 0;
	logic [7:0]  ca [5] = '{8'h20, 8'h20, 8'h21, 8'h21, 8'h20};
	int          go [5] = '{2, 0, 4, 6, 6};
	int          sl [5] = '{3, 1, 5, 7, 7};

	sed_host_model host (.clock_in(clock_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
		.addr_out(addr), .data_out(wdata));
	sed_supply_enable_dvm #(.DEGLITCH_LONG_CYCLES(20)) dut (.clock_in(clock_in),
		.rst_in(rst_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
		.wr_data_in(wdata), .rd_data_out(rdata), .factory_enable_in(fac),
		.buck_a_pin_on_in(bpa), .buck_b_pin_on_in(bpb), .linreg_four_pin_on_in(lfp),
		.sys_input_low_in(sil), .hot_reset_in(hri), .ramp_done_in(done),
		.ramp_start_out(rstart), .ramp_active_out(ract), .target_code_out(tgt),
		.supply_on_out(son), .sleep_req_out(sreq), .normal_req_out(nreq),
		.reboot_req_out(rreq), .sleep_request_exit_out(sexit), .hot_reset_out(hrst));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [12:0] sup();
		return {r[4][7], r[2][6] | r[3][6], r[2][5] | r[3][5], r[2][4] | r[3][4], r[4][6],
			r[2][3] | r[3][3], r[2][2] | r[3][2], |{r[0][3:2], r[1][3:2]}, r[2][1] | r[3][1],
			r[2][0] | r[3][0], r[2][7] | r[3][7], r[0][0] | r[1][0], r[0][1] | r[1][1]};
	endfunction
	function automatic logic [7:0] msk(input int k);
		return (k < 2) ? 8'h0F : (k == 4) ? 8'hF2 : 8'hFF;
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.cyc(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.cyc(1'b0, a, 8'h00);
	endtask
	task automatic close_out();
		if (n_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock, monitor and watchdog
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		rd_pend <= rd_en;
		hr_cnt <= hr_cnt + int'(hrst);
		sl_cnt <= sl_cnt + int'(sreq);
	end
	always @(negedge clock_in) begin
		if (rd_pend === 1'b1) check(rdata, exp_q.pop_front());
	end
	initial begin
		#200000;
		n_errors++;
		close_out();
	end

	// ==========================================================
	// Scenarios
	initial begin
		int n, i;
		logic [7:0] d, v1, v2;
		logic s;
		rst_in = 1'b1;
		{bpa, bpb, lfp, sil, hri} = 5'h00;
		done = 5'h00;
		fac[31:0] = rnd();
		fac[39:32] = 8'(rnd());
		repeat (20) @(negedge clock_in);
		rst_in = 1'b0;
		repeat (2) @(negedge clock_in);
		for (int k = 0; k < 5; k++) r[k] = (k == 4) ? {fac[39:38], 6'h00} : fac[8*k +: 8];
		check(son, sup());
		for (int k = 0; k < 5; k++) rd(8'h10 + 8'(k), r[k] & msk(k));
		for (int k = 0; k < 29; k++) begin
			i = (k < 24) ? int'(rnd() % 5) : k - 24;
			d = (k < 24) ? 8'(rnd()) : 8'h00;
			r[i] = d & msk(i);
			wr(8'h10 + 8'(i), d);
			check(son, sup());
			rd(8'h10 + 8'(i), r[i]);
		end
		{bpa, bpb, lfp} = 3'h7;
		repeat (5) @(negedge clock_in);
		check(son, 13'h0083);
		{bpa, bpb, lfp} = 3'h0;
		for (int b = 0; b < 3; b++) begin
			d = (b == 0) ? 8'h01 : (b == 1) ? 8'h04 : 8'h08;
			wr(8'h14, d | 8'h02);
			check({sreq, nreq, rreq, sexit}, {d[3], d[2], d[0], 1'b1});
			rd(8'h14, 8'h02);
		end
		for (int e = 0; e < 2; e++) begin
			wr(8'h14, e ? 8'h20 : 8'h00);
			n = sl_cnt;
			sil = 1'b1;
			repeat (8) @(negedge clock_in);
			sil = 1'b0;
			check(40'(sl_cnt - n), 40'(e));
		end
		for (int j = 0; j < 3; j++) begin
			wr(8'h14, j ? 8'h00 : 8'h10);
			n = hr_cnt;
			hri = 1'b1;
			repeat (j == 2 ? 300 : 40) @(negedge clock_in);
			hri = 1'b0;
			repeat (4) @(negedge clock_in);
			check(40'(hr_cnt - n), 40'(j != 1));
		end
		for (int c = 0; c < 5; c++) begin
			v1 = 8'(rnd());
			v2 = 8'(rnd());
			s = 1'(rnd());
			wr(sed_pkg::ADDR_VSET_BASE + 8'(2 * c), v1);
			wr(sed_pkg::ADDR_VSET_BASE + 8'(2 * c + 1), v2);
			wr(ca[c], 8'(1 << go[c]) | 8'(s) << sl[c]);
			check({rstart[c], ract[c]}, 2'h3);
			check(tgt[8*c +: 8], s ? v2 : v1);
			done[c] = 1'b1;
			@(negedge clock_in);
			done = 5'h00;
			check(ract[c], 1'b0);
			rd(ca[c], 8'(s) << sl[c]);
		end
		rd(8'h00, 8'h00);
		repeat (2) @(negedge clock_in);
		close_out();
	end
endmodule // testbench
